// >>> rtl/dac_buf_defs.svh
// Constants for the converter data buffer control block
// Overview of operation
// - One control bit picks which of two reference inputs feeds the converter.
// - While enabled, a 12-bit code from word zero or selected word goes out.
// - Buffer disabled: always convert word zero, whatever the read pointer holds.
// - Converter and buffer enabled: each trigger moves the read pointer per mode.
// - Changing the work mode leaves the read pointer as it is.
// - Software may load the read pointer with zero up to the upper limit.
// - Bottom flag sets when the read pointer equals the upper limit.
// - Top flag sets when the read pointer equals zero.
// - Outside FIFO mode, watermark flag sets when pointer reaches one to four words below limit.
// - Normal mode: increment per trigger, wrap from limit to zero next trigger.
// - Swing mode: after the limit, count down to zero, then up again.
// - One-time scan: increment per trigger, then hold at the limit.
// - One-time scan: reloaded below the limit, it climbs and stops again.
// - One-time scan: pointer loaded with the limit never advances.
// - FIFO mode: each valid buffer word write is queued, write pointer advances.
// - FIFO mode: 16-bit or 8-bit writes with address bit one set are dropped.
// - FIFO mode: 32-bit write only at even write pointer, then advances by two.
// - Writes that would overflow are dropped: any when full, 32-bit with one free.
// - 8-bit FIFO writes: address bit zero picks lane; advance after both lanes.
// - Buffer word reads return stored data and move neither pointer.
// - FIFO pushes are taken while the converter is still disabled.
// - Work mode codes: normal 00, swing 01, one-time scan 10, FIFO 11.
// - Entering FIFO: limit becomes write pointer equal to read pointer, queue empty.
// - Normal watermark codes 00 to 11 mean one to four words below the limit.
`ifndef DAC_BUF_DEFS_SVH
`define DAC_BUF_DEFS_SVH
`define BUF_PTR_W 4
`define BUF_DEPTH 16
`define CODE_W 12
`define WORD_W 16
`define LIMIT_RESET 4'hf
`define FIFO_WM_LOW 2
`endif

// >>> rtl/dac_buf_pkg.sv
// Types shared by the converter data buffer control block
`include "dac_buf_defs.svh"
package dac_buf_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SWING = 2'b01,
    MODE_ONESHOT = 2'b10,
    MODE_FIFO = 2'b11
  } work_mode_e;

  typedef enum logic [1:0] {
    SIZE_8 = 2'b00,
    SIZE_16 = 2'b01,
    SIZE_32 = 2'b11
  } access_size_e;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } sweep_dir_e;

  typedef struct packed {
    logic valid;
    access_size_e size;
    logic [`BUF_PTR_W:0] addr;
    logic [31:0] data;
  } wr_req_s;

  typedef struct packed {
    logic watermark_flag;
    logic pointer_top_flag;
    logic pointer_bottom_flag;
  } flags_s;
endpackage

// >>> rtl/dac_word_mem.sv
// Buffer word store with one pair write port and two registered read ports
`timescale 1ns/1ns
module dac_word_mem #(
  parameter int PW = 4,
  parameter int W = 16
) (
  // Clock
  input wire logic i_core_clk,
  // Write: bytes 0-1 to entry index, bytes 2-3 to entry index+1
  input wire logic [3:0] i_wr_be,
  input wire logic [PW-1:0] i_wr_index,
  input wire logic [31:0] i_wr_data,
  // Read ports
  input wire logic [PW-1:0] i_rd_a_index,
  output logic [W-1:0] o_rd_a_data,
  input wire logic [PW-1:0] i_rd_b_index,
  output logic [W-1:0] o_rd_b_data
);
  logic [W-1:0] words [2**PW];
  logic [PW-1:0] upper_index;

  assign upper_index = i_wr_index + 1'b1;

  always_ff @(posedge i_core_clk) begin
    if (i_wr_be[0]) begin
      words[i_wr_index][7:0] <= i_wr_data[7:0];
    end
    if (i_wr_be[1]) begin
      words[i_wr_index][W-1:8] <= i_wr_data[W-1:8];
    end
    if (i_wr_be[2]) begin
      words[upper_index][7:0] <= i_wr_data[23:16];
    end
    if (i_wr_be[3]) begin
      words[upper_index][W-1:8] <= i_wr_data[W+15:24];
    end
  end

  always_ff @(posedge i_core_clk) begin
    o_rd_a_data <= words[i_rd_a_index];
    o_rd_b_data <= words[i_rd_b_index];
  end
endmodule

// >>> rtl/dac_skid_buffer.sv
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ns
module dac_skid_buffer #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  logic [W-1:0] spare;
  logic spare_full;
  logic take;
  logic give;

  assign take = i_valid && o_ready;
  assign give = o_valid && i_ready;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_valid <= 1'b0;
      spare_full <= 1'b0;
      o_ready <= 1'b1;
    end else begin
      if (give || !o_valid) begin
        o_valid <= spare_full || take;
        spare_full <= spare_full && take;
      end else if (take) begin
        spare_full <= 1'b1;
      end
      o_ready <= !(spare_full || (take && o_valid && !give)) || (give && !take);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (give || !o_valid) begin
      o_data <= spare_full ? spare : i_data;
      if (take) begin
        spare <= i_data;
      end
    end else if (take) begin
      spare <= i_data;
    end
  end
endmodule

// >>> rtl/dac_data_buffer_control.sv
// Converter data buffer control: pointer modes, FIFO writes, flags and code output
`timescale 1ns/1ns
`include "dac_buf_defs.svh"
module dac_data_buffer_control #(
  parameter int PW = `BUF_PTR_W,
  parameter int REF_W = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Configuration
  input wire logic i_converter_enable,
  input wire logic i_buffer_pointer_enable,
  input wire dac_buf_pkg::work_mode_e i_buffer_work_mode,
  input wire logic [1:0] i_watermark_select,
  input wire logic i_reference_source_select,
  // Reference inputs and selected reference
  input wire logic [REF_W-1:0] i_reference_input_one,
  input wire logic [REF_W-1:0] i_reference_input_two,
  output logic [REF_W-1:0] o_reference,
  // Triggers
  input wire logic i_hw_trigger,
  input wire logic i_sw_trigger,
  // Pointer and limit loads
  input wire logic i_ptr_load,
  input wire logic [PW-1:0] i_ptr_value,
  input wire logic i_limit_load,
  input wire logic [PW-1:0] i_limit_value,
  // Buffer word writes and reads
  input wire dac_buf_pkg::wr_req_s i_wr,
  output logic o_wr_accepted,
  input wire logic i_rd_valid,
  input wire logic [PW-1:0] i_rd_index,
  output logic o_rd_valid,
  output logic [`WORD_W-1:0] o_rd_data,
  // State and flags
  output logic [PW-1:0] o_buffer_read_pointer,
  output logic [PW-1:0] o_buffer_upper_limit,
  output dac_buf_pkg::flags_s o_flags,
  input wire dac_buf_pkg::flags_s i_flags_clear,
  // Converter code stream
  output logic o_code_valid,
  output logic [`CODE_W-1:0] o_code,
  input wire logic i_code_ready
);
  import dac_buf_pkg::*;

  localparam int DEPTH = 2**PW;

  logic [PW-1:0] rp;
  logic [PW-1:0] limit;
  sweep_dir_e dir;
  logic [PW:0] count;
  logic [1:0] lanes;
  logic fifo_mode_d;
  logic trig_pend;
  logic upd_d1;
  logic push_pend;
  logic enable_d;
  logic adv;
  logic fifo;
  logic fifo_enter;
  logic wr_ok;
  logic [3:0] wr_be;
  logic [PW-1:0] wr_index;
  logic [31:0] wr_data;
  logic [1:0] wr_push;
  logic pop;
  logic [PW:0] free;
  logic [PW-1:0] next_rp;
  sweep_dir_e next_dir;
  logic [PW-1:0] conv_index;
  logic [`WORD_W-1:0] conv_word;
  logic skid_ready;
  logic [PW:0] fifo_wm;
  logic wm_hit;

  // Step of the read pointer for one trigger; returns direction and pointer
  function automatic logic [PW:0] step_ptr(input work_mode_e mode, input logic [PW-1:0] p,
                                           input logic [PW-1:0] up, input sweep_dir_e d,
                                           input logic [PW:0] cnt);
    logic [PW:0] r;
    r = {d, p};
    case (mode)
      MODE_NORMAL: begin
        r = {DIR_UP, (p == up) ? {PW{1'b0}} : PW'(p + 1'b1)};
      end
      MODE_SWING: begin
        if (up == '0) begin
          r = {DIR_UP, {PW{1'b0}}};
        end else if (d == DIR_UP) begin
          r = (p >= up) ? {DIR_DOWN, PW'(p - 1'b1)} : {DIR_UP, PW'(p + 1'b1)};
        end else begin
          r = (p == '0) ? {DIR_UP, PW'(p + 1'b1)} : {DIR_DOWN, PW'(p - 1'b1)};
        end
      end
      MODE_ONESHOT: begin
        r = {DIR_UP, (p >= up) ? p : PW'(p + 1'b1)};
      end
      MODE_FIFO: begin
        r = {DIR_UP, (cnt != '0) ? PW'(p + 1'b1) : p};
      end
      default: begin
        r = {d, p};
      end
    endcase
    return r;
  endfunction

  assign fifo = (i_buffer_work_mode == MODE_FIFO);
  assign fifo_enter = fifo && !fifo_mode_d;
  assign adv = trig_pend && i_converter_enable && i_buffer_pointer_enable && skid_ready
               && !upd_d1 && !push_pend && !i_ptr_load && !fifo_enter;
  assign pop = adv && fifo && (count != '0);
  assign {next_dir, next_rp} = step_ptr(i_buffer_work_mode, rp, limit, dir, count);
  assign free = (PW+1)'(DEPTH) - count;
  assign conv_index = i_buffer_pointer_enable ? rp : {PW{1'b0}};

  // Write decode: lanes, target entries and how many queue entries are added
  always_comb begin
    wr_ok = 1'b0;
    wr_be = 4'h0;
    wr_index = i_wr.addr[PW:1];
    wr_data = i_wr.data;
    wr_push = 2'h0;
    if (i_wr.valid && !fifo) begin
      wr_index = i_wr.addr[PW:1];
      case (i_wr.size)
        SIZE_32: begin
          wr_ok = !i_wr.addr[1] && !i_wr.addr[0];
          wr_be = 4'hf;
        end
        SIZE_16: begin
          wr_ok = !i_wr.addr[0];
          wr_be = 4'h3;
        end
        default: begin
          wr_ok = 1'b1;
          wr_be = i_wr.addr[0] ? 4'h2 : 4'h1;
          wr_data = {i_wr.data[7:0], i_wr.data[7:0], i_wr.data[7:0], i_wr.data[7:0]};
        end
      endcase
    // pushes need only the pointer enable
    end else if (i_wr.valid && i_buffer_pointer_enable) begin
      // FIFO writes target the write pointer
      wr_index = limit;
      case (i_wr.size)
        SIZE_32: begin
          wr_ok = !limit[0] && (free >= (PW+1)'(2));
          wr_be = 4'hf;
          wr_push = 2'h2;
        end
        SIZE_16: begin
          // address bit one must be clear
          wr_ok = !i_wr.addr[1] && (free != '0);
          wr_be = 4'h3;
          wr_push = 2'h1;
        end
        default: begin
          wr_ok = !i_wr.addr[1] && (free != '0);
          wr_be = i_wr.addr[0] ? 4'h2 : 4'h1;
          wr_data = {i_wr.data[7:0], i_wr.data[7:0], i_wr.data[7:0], i_wr.data[7:0]};
          wr_push = ((lanes | wr_be[1:0]) == 2'h3) ? 2'h1 : 2'h0;
        end
      endcase
    end
    if (!wr_ok) begin
      wr_be = 4'h0;
      wr_push = 2'h0;
    end
  end

  // Pending trigger, dropped while the pointer is disabled
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      trig_pend <= 1'b0;
    end else if (!(i_converter_enable && i_buffer_pointer_enable)) begin
      trig_pend <= 1'b0;
    end else begin
      trig_pend <= (trig_pend && !adv) || i_hw_trigger || i_sw_trigger;
    end
  end

  // Read pointer and sweep direction
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      rp <= {PW{1'b0}};
      dir <= DIR_UP;
    end else if (i_ptr_load) begin
      rp <= i_ptr_value;
      dir <= DIR_UP;
    end else if (adv) begin
      rp <= next_rp;
      dir <= next_dir;
    end
  end

  // Upper limit, which doubles as the write pointer in FIFO mode
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      limit <= `LIMIT_RESET;
    end else if (fifo_enter) begin
      // write pointer starts at read pointer
      limit <= rp;
    end else if (i_limit_load) begin
      limit <= i_limit_value;
    end else begin
      limit <= limit + PW'(wr_push);
    end
  end

  // Queue occupancy and byte lane pairing
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      count <= '0;
      lanes <= 2'h0;
      fifo_mode_d <= 1'b0;
    end else begin
      fifo_mode_d <= fifo;
      if (fifo_enter || !fifo) begin
        count <= '0;
        lanes <= 2'h0;
      end else if (i_limit_load || i_ptr_load) begin
        count <= {1'b0, PW'((i_limit_load ? i_limit_value : limit)
                            - (i_ptr_load ? i_ptr_value : rp))};
        lanes <= 2'h0;
      end else begin
        count <= count + (PW+1)'(wr_push) - (PW+1)'(pop);
        if (wr_ok && i_wr.size == SIZE_8) begin
          lanes <= (wr_push != 2'h0) ? 2'h0 : (lanes | wr_be[1:0]);
        end
      end
    end
  end

  dac_word_mem #(
    .PW(PW),
    .W(`WORD_W)
  ) u_mem (
    .i_core_clk(i_core_clk),
    .i_wr_be(wr_be),
    .i_wr_index(wr_index),
    .i_wr_data(wr_data),
    .i_rd_a_index(conv_index),
    .o_rd_a_data(conv_word),
    .i_rd_b_index(i_rd_index),
    .o_rd_b_data(o_rd_data)
  );

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_rd_valid <= 1'b0;
      o_wr_accepted <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_valid;
      o_wr_accepted <= wr_ok;
    end
  end

  // Code refresh: the store read lags the pointer by one edge
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      upd_d1 <= 1'b0;
      push_pend <= 1'b0;
      enable_d <= 1'b0;
    end else begin
      enable_d <= i_converter_enable;
      upd_d1 <= adv || i_ptr_load || (wr_be != 4'h0) || fifo_enter
                || (i_converter_enable && !enable_d);
      push_pend <= (push_pend && !skid_ready) || upd_d1;
    end
  end

  dac_skid_buffer #(
    .W(`CODE_W)
  ) u_skid (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_valid(push_pend && i_converter_enable),
    .i_data(conv_word[`CODE_W-1:0]),
    .o_ready(skid_ready),
    .o_valid(o_code_valid),
    .o_data(o_code),
    .i_ready(i_code_ready)
  );

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_reference <= '0;
    end else begin
      o_reference <= i_reference_source_select ? i_reference_input_two : i_reference_input_one;
    end
  end

  always_comb begin
    case (i_watermark_select)
      2'b00: fifo_wm = (PW+1)'(`FIFO_WM_LOW);
      2'b01: fifo_wm = (PW+1)'(DEPTH / 4);
      2'b10: fifo_wm = (PW+1)'(DEPTH / 2);
      default: fifo_wm = (PW+1)'(DEPTH - 2);
    endcase
    wm_hit = fifo ? (count <= fifo_wm)
                  : (rp == PW'(limit - PW'(i_watermark_select) - 1'b1));
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_flags <= '0;
    end else if (i_buffer_pointer_enable) begin
      o_flags.pointer_bottom_flag <= (rp == limit)
                                     || (o_flags.pointer_bottom_flag
                                         && !i_flags_clear.pointer_bottom_flag);
      o_flags.pointer_top_flag <= (rp == '0)
                                  || (o_flags.pointer_top_flag && !i_flags_clear.pointer_top_flag);
      o_flags.watermark_flag <= wm_hit
                                || (o_flags.watermark_flag && !i_flags_clear.watermark_flag);
    end else begin
      o_flags <= o_flags & ~i_flags_clear;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_buffer_read_pointer <= '0;
      o_buffer_upper_limit <= `LIMIT_RESET;
    end else begin
      o_buffer_read_pointer <= rp;
      o_buffer_upper_limit <= limit;
    end
  end

  sequence s_step;
    adv ##1 upd_d1;
  endsequence

  chk_code_refresh: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    s_step and i_converter_enable[*2] |-> ##[1:4] (push_pend && skid_ready))
    else $error("pointer move not followed by a code push");
  chk_word_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !i_buffer_pointer_enable |-> conv_index == '0)
    else $error("disabled pointer did not select word zero");
  chk_mode_keep: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !adv && !i_ptr_load |=> $stable(rp))
    else $error("read pointer moved without trigger or load");
  chk_ptr_load: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_ptr_load |=> rp == $past(i_ptr_value) ##1 o_buffer_read_pointer == $past(i_ptr_value, 2))
    else $error("pointer load not taken");
  chk_limit_flag: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_buffer_pointer_enable && rp == limit |=> o_flags.pointer_bottom_flag)
    else $error("upper limit flag missing");
  chk_start_flag: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_buffer_pointer_enable && rp == '0 |=> o_flags.pointer_top_flag)
    else $error("start flag missing");
  chk_normal_wrap: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    adv && i_buffer_work_mode == MODE_NORMAL && rp == limit |=> rp == '0)
    else $error("normal mode did not wrap to zero");
  chk_swing_turn: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    adv && i_buffer_work_mode == MODE_SWING && rp == limit && limit != '0
    |=> rp == $past(limit) - 1'b1 && dir == DIR_DOWN)
    else $error("swing mode did not turn down");
  chk_scan_hold: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    adv && i_buffer_work_mode == MODE_ONESHOT && rp == limit |=> $stable(rp))
    else $error("one-time scan moved past the limit");
  chk_odd_32: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    fifo && !fifo_enter && i_wr.valid && i_wr.size == SIZE_32 && limit[0] && !i_limit_load
    |=> $stable(limit) && !o_wr_accepted)
    else $error("32-bit write at odd write pointer was taken");
  chk_full_drop: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    fifo && count == (PW+1)'(DEPTH) |-> wr_push == 2'h0)
    else $error("write taken into a full queue");
endmodule

// >>> tb/dac_data_buffer_control_tb.sv
// Self-checking bench for the converter data buffer control block
`timescale 1ns/1ns
`include "dac_buf_defs.svh"
module dac_data_buffer_control_tb;
  import dac_buf_pkg::*;
  logic clk, rst_n, conv_en, ptr_en, ref_sel, ref_one, ref_two, ref_out, hw_trg, sw_trg;
  logic ptr_ld, lim_ld, wr_acc, rd_vld, rd_ok, code_vld, code_rdy;
  logic [3:0] ptr_val, lim_val, rd_idx, rp, lim;
  logic [1:0] wm_sel;
  logic [15:0] rd_data;
  logic [11:0] code;
  work_mode_e mode;
  wr_req_s wr;
  flags_s flags, flg_clr;
  logic [11:0] codes[$];
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  dac_data_buffer_control u_dut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_converter_enable(conv_en),
    .i_buffer_pointer_enable(ptr_en), .i_buffer_work_mode(mode), .i_watermark_select(wm_sel),
    .i_reference_source_select(ref_sel), .i_reference_input_one(ref_one),
    .i_reference_input_two(ref_two), .o_reference(ref_out), .i_hw_trigger(hw_trg),
    .i_sw_trigger(sw_trg), .i_ptr_load(ptr_ld), .i_ptr_value(ptr_val), .i_limit_load(lim_ld),
    .i_limit_value(lim_val), .i_wr(wr), .o_wr_accepted(wr_acc), .i_rd_valid(rd_vld),
    .i_rd_index(rd_idx), .o_rd_valid(rd_ok), .o_rd_data(rd_data),
    .o_buffer_read_pointer(rp), .o_buffer_upper_limit(lim), .o_flags(flags),
    .i_flags_clear(flg_clr), .o_code_valid(code_vld), .o_code(code), .i_code_ready(code_rdy)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Every code the converter takes, in order
  always @(posedge clk) begin
    if (code_vld === 1'b1 && code_rdy === 1'b1) begin
      codes.push_back(code);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      $display("[ERR] %0t run did not finish in time", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  function automatic logic [15:0] word(input int k);
    return 16'h00a0 + 16'(k);
  endfunction

  function automatic logic [15:0] last_code();
    if (codes.size() == 0) return 16'hxxxx;
    return {4'h0, codes[$]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic load_ptr(input logic [3:0] v);
    ptr_ld = 1'b1;
    ptr_val = v;
    tick(1);
    ptr_ld = 1'b0;
    tick(6);
  endtask

  task automatic load_lim(input logic [3:0] v);
    lim_ld = 1'b1;
    lim_val = v;
    tick(1);
    lim_ld = 1'b0;
    tick(4);
  endtask

  task automatic clear_flags();
    flg_clr = 3'b111;
    tick(1);
    flg_clr = 3'b000;
    tick(2);
  endtask

  // One trigger pulse, then the expected pointer and converted code
  task automatic trig(input logic hw, input int exp);
    hw_trg = hw;
    sw_trg = ~hw;
    tick(1);
    hw_trg = 1'b0;
    sw_trg = 1'b0;
    tick(8);
    cmp_word({12'h000, rp}, 16'(exp), "read pointer after trigger");
    cmp_word(last_code(), word(exp) & 16'h0fff, "code after trigger");
  endtask

  task automatic push(input access_size_e s, input logic [4:0] a, input logic [31:0] d,
                      input logic exp, input string m);
    logic acc;
    wr = '{1'b1, s, a, d};
    tick(1);
    wr.valid = 1'b0;
    acc = wr_acc;
    tick(1);
    acc = acc | wr_acc;
    tick(1);
    cmp_bit(acc, exp, m);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
    logic [15:0] got;
    got = 16'hxxxx;
    rd_vld = 1'b1;
    rd_idx = idx;
    tick(1);
    rd_vld = 1'b0;
    if (rd_ok === 1'b1) got = rd_data;
    tick(1);
    if (rd_ok === 1'b1) got = rd_data;
    cmp_word(got, exp, "buffer word read");
  endtask

  task automatic t_reset_ref();
    cmp_word({12'h000, rp}, 16'h0000, "pointer after reset");
    cmp_word({12'h000, lim}, {12'h000, `LIMIT_RESET}, "limit after reset");
    cmp_bit(code_vld, 1'b0, "code valid after reset");
    for (int s = 0; s < 2; s++) begin
      ref_sel = s[0];
      tick(2);
      cmp_bit(ref_out, s[0] ? ref_two : ref_one, "selected reference");
    end
  endtask

  task automatic t_fill_disabled();
    for (int k = 0; k < 16; k++) push(SIZE_16, 5'(k * 2), {16'h0000, word(k)}, 1'b1, "fill");
    load_ptr(4'h5);
    conv_en = 1'b1;
    tick(8);
    cmp_word(last_code(), word(0) & 16'h0fff, "disabled buffer converts word zero");
  endtask

  task automatic t_normal();
    ptr_en = 1'b1;
    mode = MODE_NORMAL;
    load_lim(4'h3);
    load_ptr(4'h0);
    for (int i = 1; i < 4; i++) trig(i[0], i);
    clear_flags();
    cmp_bit(flags.pointer_bottom_flag, 1'b1, "bottom flag at limit");
    cmp_bit(flags.pointer_top_flag, 1'b0, "top flag away from zero");
    trig(1'b0, 0);
    cmp_bit(flags.pointer_top_flag, 1'b1, "top flag at zero");
  endtask

  task automatic t_swing_scan();
    load_ptr(4'h2);
    mode = MODE_SWING;
    tick(3);
    cmp_word({12'h000, rp}, 16'h0002, "pointer kept over mode change");
    trig(1'b1, 3);
    trig(1'b0, 2);
    trig(1'b1, 1);
    trig(1'b1, 0);
    trig(1'b0, 1);
    mode = MODE_ONESHOT;
    load_ptr(4'h2);
    trig(1'b1, 3);
    trig(1'b0, 3);
    load_ptr(4'h1);
    trig(1'b1, 2);
    trig(1'b1, 3);
    load_ptr(4'h3);
    trig(1'b0, 3);
  endtask

  task automatic t_watermark();
    mode = MODE_NORMAL;
    load_lim(4'h7);
    for (int c = 0; c < 4; c++) begin
      wm_sel = 2'(c);
      load_ptr(4'h0);
      clear_flags();
      cmp_bit(flags.watermark_flag, 1'b0, "watermark away from mark");
      load_ptr(4'(6 - c));
      cmp_bit(flags.watermark_flag, 1'b1, "watermark at mark");
    end
  endtask

  // Receiver stalls while three codes are produced; none may be lost
  task automatic t_stall();
    tick(4);
    codes.delete();
    code_rdy = 1'b0;
    load_ptr(4'h1);
    load_ptr(4'h2);
    load_ptr(4'h3);
    cmp_bit(code_vld, 1'b1, "code held during stall");
    cmp_word({4'h0, code}, word(1) & 16'h0fff, "oldest code held");
    code_rdy = 1'b1;
    tick(10);
    cmp_word(codes.size() > 0 ? {4'h0, codes[0]} : 16'hxxxx, word(1) & 16'h0fff, "first");
    cmp_word(last_code(), word(3) & 16'h0fff, "last drained");
    cmp_bit(code_vld, 1'b0, "stream empty after drain");
  endtask

  task automatic t_fifo();
    conv_en = 1'b0;
    load_ptr(4'h1);
    mode = MODE_FIFO;
    tick(3);
    cmp_word({12'h000, lim}, 16'h0001, "write pointer starts at read pointer");
    push(SIZE_16, 5'h02, 32'h0000_1111, 1'b0, "16-bit with address bit one");
    push(SIZE_8, 5'h03, 32'h0000_0022, 1'b0, "8-bit with address bit one");
    push(SIZE_32, 5'h00, 32'h3333_4444, 1'b0, "32-bit at odd write pointer");
    push(SIZE_16, 5'h00, 32'h0000_0bb1, 1'b1, "16-bit push");
    push(SIZE_8, 5'h01, 32'h0000_00cc, 1'b1, "upper byte lane");
    cmp_word({12'h000, lim}, 16'h0002, "one lane does not advance");
    push(SIZE_8, 5'h00, 32'h0000_00dd, 1'b1, "lower byte lane");
    cmp_word({12'h000, lim}, 16'h0003, "pair advances write pointer");
    push(SIZE_16, 5'h00, 32'h0000_0cc3, 1'b1, "16-bit push");
    for (int k = 0; k < 6; k++) begin
      push(SIZE_32, 5'h04, {16'h0e01 + 16'(2 * k), 16'h0e00 + 16'(2 * k)}, 1'b1, "32-bit");
    end
    cmp_word({12'h000, lim}, 16'h0000, "32-bit pushes advance by two");
    push(SIZE_32, 5'h00, 32'h5555_6666, 1'b0, "32-bit with one free entry");
    push(SIZE_16, 5'h00, 32'h0000_0777, 1'b1, "last free entry");
    push(SIZE_16, 5'h00, 32'h0000_0888, 1'b0, "write when full");
    rd(4'h1, 16'h0bb1);
    rd(4'h2, 16'hccdd);
    rd(4'h4, 16'h0e00);
    rd(4'h5, 16'h0e01);
    cmp_word({8'h00, rp, lim}, 16'h0011, "reads move no pointer");
    load_lim(4'h1);
    push(SIZE_16, 5'h00, 32'h0000_0999, 1'b1, "push after emptying");
    mode = MODE_NORMAL;
  endtask

  initial begin
    rst_n = 1'b0;
    conv_en = 1'b0;
    ptr_en = 1'b0;
    mode = MODE_NORMAL;
    wm_sel = 2'b00;
    ref_sel = 1'b0;
    ref_one = 1'b1;
    ref_two = 1'b0;
    hw_trg = 1'b0;
    sw_trg = 1'b0;
    ptr_ld = 1'b0;
    ptr_val = 4'h0;
    lim_ld = 1'b0;
    lim_val = 4'h0;
    wr = '0;
    rd_vld = 1'b0;
    rd_idx = 4'h0;
    flg_clr = 3'b000;
    code_rdy = 1'b1;
    tick(4);
    rst_n = 1'b1;
    tick(1);
    t_reset_ref();
    t_fill_disabled();
    t_normal();
    t_swing_scan();
    t_watermark();
    t_stall();
    t_fifo();
    complete_run();
  end
endmodule
